// ### core/mrpa_defines.svh
// Constants of the media reach advertising page bank.
// Assumes inclusion by its bare name from the design files.
`ifndef MRPA_DEFINES_SVH
`define MRPA_DEFINES_SVH

`define MRPA_ADDR_SM_REACH   8'h84
`define MRPA_ADDR_WIDE_MM    8'h85
`define MRPA_ADDR_EXT_MM_A   8'h86
`define MRPA_ADDR_EXT_MM_B   8'h87
`define MRPA_ADDR_LEGACY_MM  8'h88
`define MRPA_ADDR_RSVD       8'h89
`define MRPA_ADDR_WL_NOM_HI  8'h8A
`define MRPA_ADDR_WL_NOM_LO  8'h8B
`define MRPA_ADDR_WL_TOL_HI  8'h8C
`define MRPA_ADDR_WL_TOL_LO  8'h8D
`define MRPA_ADDR_PAGES      8'h8E
`define MRPA_IMG_BASE        8'h84
`define MRPA_IMG_LAST        8'h8E
`define MRPA_IMG_BYTES       11
`define MRPA_IDX_W           4

`define MRPA_SCALE_RSVD      2'h3
`define MRPA_BANKS_RSVD      2'h3
`define MRPA_BANKS_DEF       2'h0
`define MRPA_PG_VDM_BIT      6
`define MRPA_PG_DIAG_BIT     5
`define MRPA_PG_USER_BIT     2
`define MRPA_BYTE_ZERO       8'h00
`define MRPA_WORD_ZERO       16'h0000

`endif

// ### core/mrpa_pkg.sv
// Types of the media reach advertising page bank.
// Assumes the constants header is compiled alongside.
package mrpa_pkg;
    typedef logic [7:0] mrpa_byte_t;

    typedef enum logic [1:0] {
        MRPA_ST_RESET = 2'h0,
        MRPA_ST_LOAD  = 2'h1,
        MRPA_ST_RUN   = 2'h3
    } mrpa_state_t;

    typedef struct packed {
        logic [1:0] scale;
        logic [5:0] base;
    } mrpa_sm_reach_t;
endpackage : mrpa_pkg

// ### core/mrpa_rd_if.sv
// Carrier between the bank and its read decoder.
// Assumes one clock domain; signals are combinational.
`timescale 1ns/1ps
`include "mrpa_defines.svh"
interface mrpa_rd_if;
    import mrpa_pkg::*;
    logic [7:0] addr;
    mrpa_byte_t img [`MRPA_IMG_BYTES];
    mrpa_byte_t data;
    logic       hit;

    modport owner  (output addr, output img, input data, input hit);
    modport decode (input addr, input img, output data, output hit);
endinterface : mrpa_rd_if

// ### core/mrpa_rd_decode.sv
// Byte decoder of the advertising image.
// Assumes the image lies at consecutive byte addresses.
`timescale 1ns/1ps
`include "mrpa_defines.svh"
module mrpa_rd_decode (
    mrpa_rd_if.decode rd
);
    import mrpa_pkg::*;
    wire [7:0]            off;
    wire [`MRPA_IDX_W-1:0] idx;

    // Image window check
    assign off     = rd.addr - `MRPA_IMG_BASE;
    assign idx     = off[`MRPA_IDX_W-1:0];
    assign rd.hit  = (rd.addr >= `MRPA_IMG_BASE) &&
                     (rd.addr <= `MRPA_IMG_LAST);
    assign rd.data = rd.hit ? rd.img[idx] : `MRPA_BYTE_ZERO;
endmodule : mrpa_rd_decode

// ### core/mrpa_adv_bank.sv
// Media reach, wavelength and page advertising byte bank.
// Assumes a synchronous byte read port from the management memory.
`timescale 1ns/1ps
`include "mrpa_defines.svh"
module mrpa_adv_bank (
    input  wire logic              core_clk_in,
    input  wire logic              reset_in,
    input  wire logic              clk_en_in,
    input  wire logic [7:0]        mem_addr_in,
    input  wire logic              mem_rd_in,
    input  wire logic              mem_wr_in,
    input  wire mrpa_pkg::mrpa_byte_t mem_wdata_in,
    output mrpa_pkg::mrpa_byte_t   mem_rdata_out,
    output logic                   mem_rvalid_out,
    output logic                   mem_hit_out,
    input  wire logic              cfg_separable_in,
    input  wire logic [1:0]        cfg_sm_scale_in,
    input  wire logic [5:0]        cfg_sm_base_in,
    input  wire mrpa_pkg::mrpa_byte_t cfg_wide_mm_in,
    input  wire mrpa_pkg::mrpa_byte_t cfg_ext_mm_a_in,
    input  wire mrpa_pkg::mrpa_byte_t cfg_ext_mm_b_in,
    input  wire mrpa_pkg::mrpa_byte_t cfg_legacy_mm_in,
    input  wire logic [15:0]       cfg_wl_nom_in,
    input  wire logic [15:0]       cfg_wl_tol_in,
    input  wire logic              cfg_tunable_in,
    input  wire logic              tune_upd_in,
    input  wire logic [15:0]       tune_wl_nom_in,
    input  wire logic [15:0]       tune_wl_tol_in,
    input  wire logic              cfg_vendor_diag_in,
    input  wire logic              cfg_banked_diag_in,
    input  wire logic              cfg_user_page_in,
    input  wire logic [1:0]        cfg_bank_code_in,
    output logic                   ready_out,
    output mrpa_pkg::mrpa_byte_t   sum_out
);
    import mrpa_pkg::*;

    mrpa_state_t    state_r;
    mrpa_state_t    state_nxt;
    mrpa_sm_reach_t sm_reach_r;
    mrpa_sm_reach_t sm_reach_nxt;
    mrpa_byte_t     wide_mm_r;
    mrpa_byte_t     ext_mm_a_r;
    mrpa_byte_t     ext_mm_b_r;
    mrpa_byte_t     legacy_mm_r;
    mrpa_byte_t     wide_mm_nxt;
    mrpa_byte_t     ext_mm_a_nxt;
    mrpa_byte_t     ext_mm_b_nxt;
    mrpa_byte_t     legacy_mm_nxt;
    logic [15:0]    wl_nom_r;
    logic [15:0]    wl_tol_r;
    mrpa_byte_t     pages_r;
    mrpa_byte_t     pages_nxt;
    mrpa_byte_t     sum_nxt;
    logic           ready_r;
    mrpa_byte_t     rdata_r;
    logic           rvalid_r;
    logic           hit_r;
    wire            loading;
    wire            retune;
    wire            sm_legal;
    wire [1:0]      bank_code;
    wire            wr_seen;

    mrpa_rd_if rd ();

    mrpa_rd_decode u_decode (
        .rd (rd)
    );

    // Writes are accepted and dropped
    assign wr_seen = mem_wr_in & clk_en_in;

    // Sequencer: capture once after reset, then hold; retune wavelength in run when tunable
    assign loading = clk_en_in && (state_r == MRPA_ST_LOAD);
    assign retune  = clk_en_in && (state_r == MRPA_ST_RUN) &&
                     cfg_tunable_in && tune_upd_in;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MRPA_ST_RESET: state_nxt = MRPA_ST_LOAD;
            MRPA_ST_LOAD:  state_nxt = MRPA_ST_RUN;
            MRPA_ST_RUN:   state_nxt = MRPA_ST_RUN;
            default:       state_nxt = MRPA_ST_RESET;
        endcase
    end

    // Reach bytes: zero for a cable or an unsupported type
    assign sm_legal = cfg_separable_in &&
                      (cfg_sm_scale_in != `MRPA_SCALE_RSVD);
    assign sm_reach_nxt = sm_legal ?
        {cfg_sm_scale_in, cfg_sm_base_in} :
        {`MRPA_BYTE_ZERO};
    assign wide_mm_nxt   = cfg_separable_in ? cfg_wide_mm_in :
                           `MRPA_BYTE_ZERO;
    assign ext_mm_a_nxt  = cfg_separable_in ? cfg_ext_mm_a_in :
                           `MRPA_BYTE_ZERO;
    assign ext_mm_b_nxt  = cfg_separable_in ? cfg_ext_mm_b_in :
                           `MRPA_BYTE_ZERO;
    assign legacy_mm_nxt = cfg_separable_in ? cfg_legacy_mm_in :
                           `MRPA_BYTE_ZERO;

    // Supported pages byte, reserved bits zero
    assign bank_code = (cfg_bank_code_in == `MRPA_BANKS_RSVD) ?
                       `MRPA_BANKS_DEF : cfg_bank_code_in;
    always_comb begin
        pages_nxt = `MRPA_BYTE_ZERO;
        pages_nxt[`MRPA_PG_VDM_BIT]  = cfg_vendor_diag_in;
        pages_nxt[`MRPA_PG_DIAG_BIT] = cfg_banked_diag_in;
        pages_nxt[`MRPA_PG_USER_BIT] = cfg_user_page_in;
        pages_nxt[1:0] = bank_code;
    end

    // Static image bytes held in flops, loaded once; wavelength bytes below
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_r     <= MRPA_ST_RESET;
            sm_reach_r  <= `MRPA_BYTE_ZERO;
            wide_mm_r   <= `MRPA_BYTE_ZERO;
            ext_mm_a_r  <= `MRPA_BYTE_ZERO;
            ext_mm_b_r  <= `MRPA_BYTE_ZERO;
            legacy_mm_r <= `MRPA_BYTE_ZERO;
            pages_r     <= `MRPA_BYTE_ZERO;
        end else if (clk_en_in) begin
            state_r <= state_nxt;
            if (loading) begin
                sm_reach_r  <= sm_reach_nxt;
                wide_mm_r   <= wide_mm_nxt;
                ext_mm_a_r  <= ext_mm_a_nxt;
                ext_mm_b_r  <= ext_mm_b_nxt;
                legacy_mm_r <= legacy_mm_nxt;
                pages_r     <= pages_nxt;
            end
        end
    end

    // Wavelength: fixed value, or value in effect when tunable
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            wl_nom_r <= `MRPA_WORD_ZERO;
            wl_tol_r <= `MRPA_WORD_ZERO;
        end else if (loading) begin
            wl_nom_r <= cfg_wl_nom_in;
            wl_tol_r <= cfg_wl_tol_in;
        end else if (retune) begin
            wl_nom_r <= tune_wl_nom_in;
            wl_tol_r <= tune_wl_tol_in;
        end
    end

    // Image in address order, high byte first
    assign rd.addr   = mem_addr_in;
    assign rd.img[0] = sm_reach_r;
    assign rd.img[1] = wide_mm_r;
    assign rd.img[2] = ext_mm_a_r;
    assign rd.img[3] = ext_mm_b_r;
    assign rd.img[4] = legacy_mm_r;
    assign rd.img[5] = `MRPA_BYTE_ZERO;
    assign rd.img[6] = wl_nom_r[15:8];
    assign rd.img[7] = wl_nom_r[7:0];
    assign rd.img[8] = wl_tol_r[15:8];
    assign rd.img[9] = wl_tol_r[7:0];
    assign rd.img[10] = pages_r;

    // Contribution to page checksum, modulo 256
    assign sum_nxt = sm_reach_r + wide_mm_r + ext_mm_a_r + ext_mm_b_r +
                     legacy_mm_r + wl_nom_r[15:8] + wl_nom_r[7:0] +
                     wl_tol_r[15:8] + wl_tol_r[7:0] + pages_r;

    // Registered read answer and status
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rdata_r  <= `MRPA_BYTE_ZERO;
            rvalid_r <= 1'b0;
            hit_r    <= 1'b0;
            ready_r  <= 1'b0;
            sum_out  <= `MRPA_BYTE_ZERO;
        end else if (clk_en_in) begin
            rvalid_r <= mem_rd_in;
            rdata_r  <= mem_rd_in ? rd.data : `MRPA_BYTE_ZERO;
            hit_r    <= mem_rd_in & rd.hit;
            ready_r  <= (state_nxt == MRPA_ST_RUN);
            sum_out  <= sum_nxt;
        end
    end

    assign mem_rdata_out  = rdata_r;
    assign mem_rvalid_out = rvalid_r;
    assign mem_hit_out    = hit_r;
    assign ready_out      = ready_r;

    // Checks
    sequence s_load;
        clk_en_in && (state_r == MRPA_ST_LOAD);
    endsequence

    sequence s_read(logic [7:0] a);
        mem_rd_in && clk_en_in && (mem_addr_in == a);
    endsequence

    a_unsup_zero: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        s_load and (cfg_wide_mm_in == `MRPA_BYTE_ZERO)
        |=> wide_mm_r == `MRPA_BYTE_ZERO)
        else $error("unsupported reach not zero");

    a_cable_zero: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        s_load and !cfg_separable_in |=> (sm_reach_r == `MRPA_BYTE_ZERO)
        && (wide_mm_r == `MRPA_BYTE_ZERO)
        && (legacy_mm_r == `MRPA_BYTE_ZERO))
        else $error("cable reach not zero");

    a_scale_legal: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        sm_reach_r.scale != `MRPA_SCALE_RSVD)
        else $error("reserved scale reported");

    a_sm_packing: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        s_load and sm_legal
        |=> sm_reach_r == {$past(cfg_sm_scale_in), $past(cfg_sm_base_in)})
        else $error("single-mode byte wrong");

    a_read_wide: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        s_read(`MRPA_ADDR_WIDE_MM)
        |=> mem_rvalid_out && mem_hit_out
        && (mem_rdata_out == $past(wide_mm_r)))
        else $error("wideband reach read wrong");

    a_read_legacy: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        s_read(`MRPA_ADDR_LEGACY_MM)
        |=> mem_rdata_out == $past(legacy_mm_r))
        else $error("legacy reach read wrong");

    a_read_nom_hi: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        s_read(`MRPA_ADDR_WL_NOM_HI)
        |=> mem_rdata_out == $past(wl_nom_r[15:8]))
        else $error("wavelength high byte wrong");

    a_read_tol_lo: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        s_read(`MRPA_ADDR_WL_TOL_LO)
        |=> mem_rdata_out == $past(wl_tol_r[7:0]))
        else $error("spread low byte wrong");

    a_retune_take: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        retune |=> (wl_nom_r == $past(tune_wl_nom_in))
        && (wl_tol_r == $past(tune_wl_tol_in)))
        else $error("tuned wavelength not taken");

    a_pages_bits: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        (pages_r[1:0] != `MRPA_BANKS_RSVD) && !pages_r[7]
        && !pages_r[4] && !pages_r[3])
        else $error("reserved page bits set");

    a_static_run: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        (state_r == MRPA_ST_RUN) |=> $stable(sm_reach_r)
        && $stable(pages_r) && $stable(ext_mm_b_r))
        else $error("static field changed");

    a_write_void: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        wr_seen && !retune && (state_r == MRPA_ST_RUN)
        |=> $stable(wl_nom_r) && $stable(wide_mm_r))
        else $error("write altered contents");

    a_rsvd_read: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        s_read(`MRPA_ADDR_RSVD) |=> mem_rdata_out == `MRPA_BYTE_ZERO)
        else $error("reserved byte not zero");

    a_read_ext_b: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        s_read(`MRPA_ADDR_EXT_MM_B)
        |=> mem_rdata_out == $past(ext_mm_b_r))
        else $error("extended reach b read wrong");

    a_read_miss: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        mem_rd_in && clk_en_in && !rd.hit
        |=> mem_rvalid_out && !mem_hit_out
        && (mem_rdata_out == `MRPA_BYTE_ZERO))
        else $error("unmapped read answered wrong");

    a_ready_load: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        s_load |=> ready_out)
        else $error("ready not raised after load");

    a_pages_flags: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        s_load |=> (pages_r[`MRPA_PG_VDM_BIT] == $past(cfg_vendor_diag_in))
        && (pages_r[`MRPA_PG_DIAG_BIT] == $past(cfg_banked_diag_in))
        && (pages_r[`MRPA_PG_USER_BIT] == $past(cfg_user_page_in)))
        else $error("page flags not captured");

    a_freeze_hold: assert property (@(posedge core_clk_in)
        disable iff (reset_in)
        !clk_en_in |=> $stable(mem_rdata_out) && $stable(mem_rvalid_out)
        && $stable(state_r) && $stable(wl_nom_r))
        else $error("state moved while disabled");
endmodule : mrpa_adv_bank

// ### testbench/mrpa_host_model.sv
// Host model that reads and writes the advertising byte bank.
// Assumes the bank answers a read one enabled cycle after it is taken.
`timescale 1ns/1ps
module mrpa_host_model
    import mrpa_pkg::*;
(
    input  wire logic       core_clk_in,
    output logic [7:0]      mem_addr_out,
    output logic            mem_rd_out,
    output logic            mem_wr_out,
    output mrpa_byte_t      mem_wdata_out,
    input  wire mrpa_byte_t mem_rdata_in,
    input  wire logic       mem_rvalid_in,
    input  wire logic       mem_hit_in
);
    initial begin
        mem_addr_out  = 8'h00;
        mem_rd_out    = 1'b0;
        mem_wr_out    = 1'b0;
        mem_wdata_out = 8'h00;
    end

    // Released strobes drop to zero; address and data lines show the inverse of their last value
    task automatic release_bus();
        mem_rd_out    = 1'b0;
        mem_wr_out    = 1'b0;
        mem_addr_out  = ~mem_addr_out;
        mem_wdata_out = ~mem_wdata_out;
    endtask : release_bus

    task automatic read(input logic [7:0] a, output mrpa_byte_t d,
                        output logic v, output logic h);
        @(posedge core_clk_in);
        #1;
        mem_addr_out = a;
        mem_rd_out   = 1'b1;
        @(posedge core_clk_in);
        #1;
        release_bus();
        v = mem_rvalid_in;
        d = mem_rdata_in;
        h = mem_hit_in;
    endtask : read

    task automatic write(input logic [7:0] a, input mrpa_byte_t wd);
        @(posedge core_clk_in);
        #1;
        mem_addr_out  = a;
        mem_wdata_out = wd;
        mem_wr_out    = 1'b1;
        @(posedge core_clk_in);
        #1;
        release_bus();
    endtask : write
endmodule : mrpa_host_model

// ### testbench/testbench.sv
// Self-checking bench of the advertising byte bank.
// Assumes the host model owns the read port; enable drops once a pass.
`timescale 1ns/1ps
module testbench;
    import mrpa_pkg::*;
    logic        clk, rst, sep, tun, upd, vd, bd, ub, rv, hit, rdy, v, h;
    logic        rd, wr, en;
    logic [1:0]  scl, bnk;
    logic [5:0]  base;
    logic [7:0]  addr;
    logic [15:0] nom, tol, tnom, ttol;
    mrpa_byte_t  wide, exa, exb, leg, wd, rdat, sum, d;
    mrpa_byte_t  exp_b [11];
    logic [7:0]  bad [3] = '{8'h83, 8'h8F, 8'h00};
    logic [1:0]  scl_t [5] = '{2'h1, 2'h3, 2'h0, 2'h2, 2'h1};
    logic [1:0]  bnk_t [5] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h2};
    logic [4:0]  sep_t = 5'h0F;
    logic [4:0]  tun_t = 5'h12;
    int          error_cnt, n_compared, cyc;

    mrpa_adv_bank u_dut (
        .core_clk_in(clk), .reset_in(rst), .clk_en_in(en),
        .mem_addr_in(addr), .mem_rd_in(rd), .mem_wr_in(wr),
        .mem_wdata_in(wd), .mem_rdata_out(rdat), .mem_rvalid_out(rv),
        .mem_hit_out(hit), .cfg_separable_in(sep), .cfg_sm_scale_in(scl),
        .cfg_sm_base_in(base), .cfg_wide_mm_in(wide),
        .cfg_ext_mm_a_in(exa), .cfg_ext_mm_b_in(exb),
        .cfg_legacy_mm_in(leg), .cfg_wl_nom_in(nom), .cfg_wl_tol_in(tol),
        .cfg_tunable_in(tun), .tune_upd_in(upd), .tune_wl_nom_in(tnom),
        .tune_wl_tol_in(ttol), .cfg_vendor_diag_in(vd),
        .cfg_banked_diag_in(bd), .cfg_user_page_in(ub),
        .cfg_bank_code_in(bnk), .ready_out(rdy), .sum_out(sum)
    );

    mrpa_host_model u_host (
        .core_clk_in(clk), .mem_addr_out(addr), .mem_rd_out(rd),
        .mem_wr_out(wr), .mem_wdata_out(wd), .mem_rdata_in(rdat),
        .mem_rvalid_in(rv), .mem_hit_in(hit)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic check(input string n, input mrpa_byte_t s,
                         input mrpa_byte_t e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic calc_exp();
        exp_b[0] = (sep && scl != 2'h3) ? {scl, base} : 8'h00;
        exp_b[1] = sep ? wide : 8'h00;
        exp_b[2] = sep ? exa : 8'h00;
        exp_b[3] = sep ? exb : 8'h00;
        exp_b[4] = sep ? leg : 8'h00;
        exp_b[5] = 8'h00;
        {exp_b[6], exp_b[7]} = nom;
        {exp_b[8], exp_b[9]} = tol;
        exp_b[10] = {1'b0, vd, bd, 2'b00, ub, 2'h0};
        exp_b[10][1:0] = (bnk == 2'h3) ? 2'h0 : bnk;
    endtask : calc_exp

    task automatic do_reset();
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("rvalid in reset", {7'h00, rv}, 8'h00);
        rst = 1'b0;
        repeat (10) begin
            @(posedge clk);
            #1;
            if (rdy === 1'b1) break;
        end
        check("ready", {7'h00, rdy}, 8'h01);
        calc_exp();
    endtask : do_reset

    task automatic check_img();
        mrpa_byte_t s;
        s = 8'h00;
        for (int i = 0; i < 11; i++) begin
            u_host.read(8'h84 + 8'(i), d, v, h);
            check($sformatf("byte %h", 8'h84 + 8'(i)), d, exp_b[i]);
            check("hit", {6'h00, v, h}, 8'h03);
            s = s + exp_b[i];
        end
        foreach (bad[j]) begin
            u_host.read(bad[j], d, v, h);
            check("unmapped", d, 8'h00);
            check("unmapped hit", {6'h00, v, h}, 8'h02);
        end
        check("sum", sum, s);
    endtask : check_img

    task automatic freeze_check();
        u_host.read(8'h8E, d, v, h);
        check("pages before freeze", d, exp_b[10]);
        en = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("frozen data", rdat, exp_b[10]);
        check("frozen valid", {6'h00, rv, hit}, 8'h03);
        check("frozen ready", {7'h00, rdy}, 8'h01);
        en = 1'b1;
    endtask : freeze_check

    task automatic end_of_test();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        {sep, tun, upd, vd, bd, ub, scl, bnk, base} = '0;
        en = 1'b1;
        {wide, exb, nom} = '0;
        exa = 8'hC3;
        leg = 8'hFF;
        tol = 16'h002F;
        tnom = 16'h65BF;
        ttol = 16'h061E;
        error_cnt = 0;
        n_compared = 0;
        cyc = 0;
        for (int k = 0; k < 5; k++) begin
            sep = sep_t[k];
            tun = tun_t[k];
            scl = scl_t[k];
            bnk = bnk_t[k];
            base = 6'h2A ^ 6'(k);
            wide = (k == 1) ? 8'h00 : 8'h55 + 8'(k);
            exb = 8'h01 ^ 8'(k);
            nom = 16'h77DD + 16'(k);
            vd = k[0];
            bd = k[1];
            ub = ~k[0];
            do_reset();
            check_img();
            u_host.write(8'h85, 8'h00);
            u_host.write(8'h89, 8'hFF);
            {sep, scl, base, wide, exa, exb} = ~{sep, scl, base, wide, exa, exb};
            {leg, nom, tol, vd, bd, ub} = ~{leg, nom, tol, vd, bd, ub};
            upd = 1'b1;
            @(posedge clk);
            #1;
            upd = 1'b0;
            if (tun) begin
                {exp_b[6], exp_b[7], exp_b[8], exp_b[9]} = {tnom, ttol};
            end
            check_img();
            freeze_check();
        end
        end_of_test();
    end
endmodule : testbench
